// >>> inc/exd_defs.svh
/*
 * Constants of the extended instruction decoder: opcodes, field positions,
 * reset values and fixed steps.
 * Assumes inclusion by bare name from the decoder sources.
 */
`ifndef EXD_DEFS_SVH
`define EXD_DEFS_SVH

// Opcode high bytes, the single-word call opcode, the second-word prefix and the return selector
`define EXD_OP_ADD_PTR   8'hE8
`define EXD_OP_SUB_PTR   8'hE9
`define EXD_OP_PUSH_LIT  8'hEA
`define EXD_OP_MOVE_IDX  8'hEB
`define EXD_OP_CALL_W    16'h0014
`define EXD_W2_PREFIX    4'hF
`define EXD_SEL_RETURN   2'b11

// Field positions inside an instruction word
`define EXD_HI_MSB       15
`define EXD_HI_LSB       8
`define EXD_SEL_MSB      7
`define EXD_SEL_LSB      6
`define EXD_K6_MSB       5
`define EXD_Z7_MSB       6
`define EXD_LIT_MSB      7
`define EXD_MODE_BIT     7
`define EXD_DST_MSB      11
`define EXD_PFX_LSB      12

// Reset values and steps
`define EXD_PTR_RST      12'h000
`define EXD_PC_RST       21'h0_0000
`define EXD_BYTE_ZERO    8'h00
`define EXD_RET_STEP     21'h0_0002
`define EXD_PUSH_STEP    12'h001

// Indirect register window (arbitrary defaults)
`define EXD_INDIR_LO     12'hFE0
`define EXD_INDIR_HI     12'hFEF

`endif

// >>> inc/exd_pkg.sv
/*
 * Types of the extended instruction decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package exd_pkg;

    typedef enum logic [2:0] {
        EXD_IDLE    = 3'b001,
        EXD_RET_NOP = 3'b010,
        EXD_MOVE_W2 = 3'b100
    } exd_state_t;

endpackage : exd_pkg

// >>> src/exd_decode.sv
/*
 * Decode and execute logic for the eight extended core instructions.
 * Assumes the core offers one word per cycle with instr_valid, honours
 * instr_ready, and reads data memory combinationally while mem_rd_en_q is high.
 */
`timescale 1ns/10ps
`include "exd_defs.svh"

module exd_decode
    import exd_pkg::*;
#(
    parameter int          PW       = 12,
    parameter int          AW       = 21,
    parameter logic [11:0] INDIR_LO = `EXD_INDIR_LO,
    parameter logic [11:0] INDIR_HI = `EXD_INDIR_HI
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    // Configuration
    input  wire logic                 extended_set_enable,
    // Instruction stream
    input  wire logic                 instr_valid,
    input  wire logic [15:0]          instr_word,
    output logic                      instr_ready,
    output logic                      ext_claim,
    // Core state
    input  wire logic [AW-1:0]        pc_in,
    input  wire logic [AW-1:0]        return_stack_top,
    input  wire logic [7:0]           working_register,
    input  wire logic [7:0]           counter_latch_high,
    input  wire logic [4:0]           counter_latch_upper,
    // Program counter and return stack
    output logic                      pc_load_q,
    output logic      [AW-1:0]        pc_load_value_q,
    output logic                      stack_push_q,
    output logic      [AW-1:0]        stack_push_value_q,
    output logic                      stack_pop_q,
    // Data memory
    output logic                      mem_rd_en_q,
    output logic      [PW-1:0]        mem_rd_addr_q,
    input  wire logic [7:0]           mem_rd_data,
    output logic                      mem_wr_en_q,
    output logic      [PW-1:0]        mem_wr_addr_q,
    output logic      [7:0]           mem_wr_data_q,
    // Pointers
    output logic      [2:0][PW-1:0]   file_select_pointer
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] base,
                                               input logic [PW-1:0] delta,
                                               input logic          sub);
        ptr_step = sub ? base - delta : base + delta;
    endfunction : ptr_step

    function automatic logic is_indirect(input logic [PW-1:0] addr);
        is_indirect = (addr >= INDIR_LO) && (addr <= INDIR_HI);
    endfunction : is_indirect

    function automatic logic is_ext_op(input logic [15:0] w);
        logic [7:0] hi;
        hi = w[`EXD_HI_MSB:`EXD_HI_LSB];
        is_ext_op = (hi == `EXD_OP_ADD_PTR) || (hi == `EXD_OP_SUB_PTR)
                 || (hi == `EXD_OP_PUSH_LIT) || (hi == `EXD_OP_MOVE_IDX)
                 || (w == `EXD_OP_CALL_W);
    endfunction : is_ext_op

    ////////////////////////////////////////////////////////////////////////
    // Fields and handshake

    exd_state_t      state_q, state_d;
    logic [7:0]      op_hi;
    logic [1:0]      op_sel;
    logic [PW-1:0]   op_k6, op_z7, frame_ptr;
    logic            take;
    logic            ptr_we;
    logic [1:0]      ptr_sel;
    logic [PW-1:0]   ptr_wd;

    assign op_hi     = instr_word[`EXD_HI_MSB:`EXD_HI_LSB];
    assign op_sel    = instr_word[`EXD_SEL_MSB:`EXD_SEL_LSB];
    assign op_k6     = {6'h0, instr_word[`EXD_K6_MSB:0]};
    assign op_z7     = {5'h0, instr_word[`EXD_Z7_MSB:0]};
    assign frame_ptr = file_select_pointer[2];
    // Return and call second cycle is a bubble
    assign instr_ready = (state_q != EXD_RET_NOP);
    assign take        = instr_valid && instr_ready;
    assign ext_claim   = take && (state_q == EXD_MOVE_W2
                       || (extended_set_enable && is_ext_op(instr_word)));

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic            pc_load_d, push_d, pop_d, rd_en_d, wr_en_d;
    logic [AW-1:0]   pc_val_d, push_val_d;
    logic [PW-1:0]   rd_addr_d, wr_addr_d, dst_addr;
    logic [7:0]      wr_data_d, rd_data_d, rd_data_q, src_byte;
    logic            src_ind_d, src_ind_q, mv_idx_d, mv_idx_q;

    always_comb begin
        state_d    = state_q;
        ptr_we     = 1'b0;
        ptr_sel    = 2'd0;
        ptr_wd     = `EXD_PTR_RST;
        pc_load_d  = 1'b0;
        pc_val_d   = pc_load_value_q;
        push_d     = 1'b0;
        push_val_d = stack_push_value_q;
        pop_d      = 1'b0;
        rd_en_d    = 1'b0;
        rd_addr_d  = mem_rd_addr_q;
        wr_en_d    = 1'b0;
        wr_addr_d  = mem_wr_addr_q;
        wr_data_d  = mem_wr_data_q;
        src_ind_d  = src_ind_q;
        mv_idx_d   = mv_idx_q;
        // Indirect source yields zero
        src_byte   = src_ind_q ? `EXD_BYTE_ZERO : mem_rd_data;
        rd_data_d  = mem_rd_en_q ? src_byte : rd_data_q;
        dst_addr   = mv_idx_q ? ptr_step(frame_ptr, op_z7, 1'b0)
                              : instr_word[`EXD_DST_MSB:0];
        case (state_q)
            EXD_IDLE: begin
                if (take && extended_set_enable) begin
                    if (op_hi == `EXD_OP_ADD_PTR || op_hi == `EXD_OP_SUB_PTR) begin
                        ptr_we = 1'b1;
                        ptr_wd = ptr_step(file_select_pointer[op_sel], op_k6,
                                          op_hi == `EXD_OP_SUB_PTR);
                        ptr_sel = op_sel;
                        if (op_sel == `EXD_SEL_RETURN) begin
                            ptr_sel   = 2'd2;
                            ptr_wd    = ptr_step(frame_ptr, op_k6,
                                                 op_hi == `EXD_OP_SUB_PTR);
                            pc_load_d = 1'b1;
                            pc_val_d  = return_stack_top;
                            pop_d     = 1'b1;
                            state_d   = EXD_RET_NOP;
                        end
                    end else if (op_hi == `EXD_OP_PUSH_LIT) begin
                        wr_en_d   = 1'b1;
                        wr_addr_d = frame_ptr;
                        wr_data_d = instr_word[`EXD_LIT_MSB:0];
                        ptr_we    = 1'b1;
                        ptr_sel   = 2'd2;
                        ptr_wd    = ptr_step(frame_ptr, `EXD_PUSH_STEP, 1'b1);
                    end else if (op_hi == `EXD_OP_MOVE_IDX) begin
                        rd_en_d   = 1'b1;
                        rd_addr_d = ptr_step(frame_ptr, op_z7, 1'b0);
                        src_ind_d = is_indirect(rd_addr_d);
                        mv_idx_d  = instr_word[`EXD_MODE_BIT];
                        state_d   = EXD_MOVE_W2;
                    end else if (instr_word == `EXD_OP_CALL_W) begin
                        // Push uses the old PC; W, status and bank untouched
                        push_d     = 1'b1;
                        push_val_d = pc_in + `EXD_RET_STEP;
                        pc_load_d  = 1'b1;
                        pc_val_d   = {counter_latch_upper, counter_latch_high,
                                      working_register};
                        state_d    = EXD_RET_NOP;
                    end
                end
            end
            EXD_RET_NOP: begin
                state_d = EXD_IDLE;
            end
            EXD_MOVE_W2: begin
                if (take) begin
                    state_d = EXD_IDLE;
                    // A second word without the prefix aborts the move
                    if (instr_word[15:`EXD_PFX_LSB] == `EXD_W2_PREFIX) begin
                        wr_addr_d = dst_addr;
                        wr_data_d = mem_rd_en_q ? src_byte : rd_data_q;
                        wr_en_d   = !(mv_idx_q && is_indirect(dst_addr));
                    end
                end
            end
            default: begin
                state_d = EXD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q            <= EXD_IDLE;
            pc_load_q          <= 1'b0;
            pc_load_value_q    <= `EXD_PC_RST;
            stack_push_q       <= 1'b0;
            stack_push_value_q <= `EXD_PC_RST;
            stack_pop_q        <= 1'b0;
            mem_rd_en_q        <= 1'b0;
            mem_rd_addr_q      <= `EXD_PTR_RST;
            mem_wr_en_q        <= 1'b0;
            mem_wr_addr_q      <= `EXD_PTR_RST;
            mem_wr_data_q      <= `EXD_BYTE_ZERO;
            rd_data_q          <= `EXD_BYTE_ZERO;
            src_ind_q          <= 1'b0;
            mv_idx_q           <= 1'b0;
        end else begin
            state_q            <= state_d;
            pc_load_q          <= pc_load_d;
            pc_load_value_q    <= pc_val_d;
            stack_push_q       <= push_d;
            stack_push_value_q <= push_val_d;
            stack_pop_q        <= pop_d;
            mem_rd_en_q        <= rd_en_d;
            mem_rd_addr_q      <= rd_addr_d;
            mem_wr_en_q        <= wr_en_d;
            mem_wr_addr_q      <= wr_addr_d;
            mem_wr_data_q      <= wr_data_d;
            rd_data_q          <= rd_data_d;
            src_ind_q          <= src_ind_d;
            mv_idx_q           <= mv_idx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer bank

    exd_ptr_file #(
        .PW (PW),
        .NP (3)
    ) u_ptr_file (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .wr_en   (ptr_we),
        .wr_sel  (ptr_sel),
        .wr_data (ptr_wd),
        .ptr_q   (file_select_pointer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic idle_go, is_ret, is_call;
    assign idle_go = take && extended_set_enable && (state_q == EXD_IDLE);
    assign is_ret  = idle_go && op_sel == `EXD_SEL_RETURN
                  && (op_hi == `EXD_OP_ADD_PTR || op_hi == `EXD_OP_SUB_PTR);
    assign is_call = idle_go && instr_word == `EXD_OP_CALL_W;

    a_add_ptr_sum: assert property (
        idle_go && op_hi == `EXD_OP_ADD_PTR && op_sel != `EXD_SEL_RETURN
        |=> file_select_pointer[$past(op_sel)]
            == PW'($past(file_select_pointer[op_sel]) + $past(op_k6)))
        else $error("pointer add result wrong");

    a_sub_ret_flow: assert property (
        is_ret && op_hi == `EXD_OP_SUB_PTR
        |=> pc_load_q && stack_pop_q && !instr_ready
            && pc_load_value_q == $past(return_stack_top)
            && frame_ptr == PW'($past(frame_ptr) - $past(op_k6))
        ##1 instr_ready)
        else $error("subtract and return sequence wrong");

    a_add_ret_flow: assert property (
        is_ret && op_hi == `EXD_OP_ADD_PTR
        |=> pc_load_q && stack_pop_q && !instr_ready
            && frame_ptr == PW'($past(frame_ptr) + $past(op_k6))
        ##1 !pc_load_q && instr_ready)
        else $error("add and return sequence wrong");

    a_call_push: assert property (
        is_call |=> stack_push_q && stack_push_value_q == AW'($past(pc_in) + 2))
        else $error("call pushed wrong return address");

    a_call_target: assert property (
        is_call |=> pc_load_q && pc_load_value_q == {$past(counter_latch_upper),
                    $past(counter_latch_high), $past(working_register)}
        ##1 !pc_load_q && !stack_push_q)
        else $error("call target wrong");

    a_disabled_quiet: assert property (
        !extended_set_enable && state_q == EXD_IDLE
        |-> !ext_claim ##1 (!pc_load_q && !stack_push_q && !mem_wr_en_q
                           && !mem_rd_en_q && !stack_pop_q))
        else $error("activity while extension disabled");

    a_push_frame: assert property (
        idle_go && op_hi == `EXD_OP_PUSH_LIT
        |=> mem_wr_en_q && mem_wr_addr_q == $past(frame_ptr)
            && mem_wr_data_q == $past(instr_word[7:0])
            && frame_ptr == PW'($past(frame_ptr) - 1))
        else $error("push literal wrong");

    a_move_src: assert property (
        idle_go && op_hi == `EXD_OP_MOVE_IDX
        |=> mem_rd_en_q && mem_rd_addr_q == PW'($past(frame_ptr) + $past(op_z7))
            && state_q == EXD_MOVE_W2)
        else $error("move source address wrong");

    a_src_zero: assert property (
        mem_rd_en_q && src_ind_q |=> rd_data_q == `EXD_BYTE_ZERO)
        else $error("indirect source not zero");

    a_dest_ind_nop: assert property (
        state_q == EXD_MOVE_W2 && take && mv_idx_q && is_indirect(dst_addr)
        |=> !mem_wr_en_q)
        else $error("indirect destination written");

    c_call: cover property (is_call ##2 instr_ready);
    c_ret: cover property (is_ret);
    c_move_idx: cover property (idle_go && op_hi == `EXD_OP_MOVE_IDX
                                ##[1:4] mem_wr_en_q);

endmodule : exd_decode

// >>> src/exd_ptr_file.sv
/*
 * File select pointer bank: one write port, all pointers read from flops.
 * Assumes one write per cycle from the decoder.
 */
`timescale 1ns/10ps
`include "exd_defs.svh"

module exd_ptr_file
    import exd_pkg::*;
#(
    parameter int PW = 12,
    parameter int NP = 3
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // Write port
    input  wire logic                   wr_en,
    input  wire logic [1:0]             wr_sel,
    input  wire logic [PW-1:0]          wr_data,
    // Pointer values
    output logic      [NP-1:0][PW-1:0]  ptr_q
);

    logic [NP-1:0][PW-1:0] ptr_d;

    always_comb begin
        ptr_d = ptr_q;
        for (int i = 0; i < NP; i++) begin
            if (wr_en && (int'(wr_sel) == i)) begin
                ptr_d[i] = wr_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= '{default: `EXD_PTR_RST};
        end else begin
            ptr_q <= ptr_d;
        end
    end

endmodule : exd_ptr_file

// >>> tb/exd_decode_bench.sv
/*
 * Self-checking bench of the extended instruction decoder: random and
 * corner-case instruction streams, expectations from bench functions.
 * Assumes exd_pkg and exd_defs.svh are compiled and on the include path.
 */
`timescale 1ns/10ps
`include "exd_defs.svh"

module exd_decode_bench;
    import exd_pkg::*;

    logic                  clk_sys = 1'b0;
    logic                  rstn = 1'b0;
    logic                  extended_set_enable = 1'b1;
    logic                  instr_valid = 1'b0;
    logic [15:0]           instr_word = 16'h0000;
    logic                  instr_ready, ext_claim;
    logic [20:0]           pc_in = 21'h0, return_stack_top = 21'h0;
    logic [7:0]            working_register = 8'h00, counter_latch_high = 8'h00;
    logic [4:0]            counter_latch_upper = 5'h00;
    logic                  pc_load_q, stack_push_q, stack_pop_q, mem_rd_en_q, mem_wr_en_q;
    logic [20:0]           pc_load_value_q, stack_push_value_q;
    logic [11:0]           mem_rd_addr_q, mem_wr_addr_q;
    logic [7:0]            mem_rd_data, mem_wr_data_q;
    logic [2:0][11:0]      file_select_pointer;
    logic [4:0]            strobes;
    logic [11:0]           ptr_m [3];
    logic [31:0]           seed = 32'h340c_b3b9;
    int                    num_errors = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    always #5 clk_sys = ~clk_sys;

    function automatic logic [7:0] mval(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'ha5;
    endfunction : mval

    // Not-read cycles show the inverse so a stale byte cannot pass
    assign mem_rd_data = mem_rd_en_q ? mval(mem_rd_addr_q) : ~mval(mem_rd_addr_q);
    assign strobes = {pc_load_q, stack_push_q, stack_pop_q, mem_rd_en_q, mem_wr_en_q};

    exd_decode u_exd_decode (
        .clk_sys(clk_sys), .rstn(rstn), .extended_set_enable(extended_set_enable),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
        .ext_claim(ext_claim), .pc_in(pc_in), .return_stack_top(return_stack_top),
        .working_register(working_register), .counter_latch_high(counter_latch_high),
        .counter_latch_upper(counter_latch_upper), .pc_load_q(pc_load_q),
        .pc_load_value_q(pc_load_value_q), .stack_push_q(stack_push_q),
        .stack_push_value_q(stack_push_value_q), .stack_pop_q(stack_pop_q),
        .mem_rd_en_q(mem_rd_en_q), .mem_rd_addr_q(mem_rd_addr_q),
        .mem_rd_data(mem_rd_data), .mem_wr_en_q(mem_wr_en_q),
        .mem_wr_addr_q(mem_wr_addr_q), .mem_wr_data_q(mem_wr_data_q),
        .file_select_pointer(file_select_pointer)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [11:0] step(input logic [11:0] p, input logic [11:0] d,
                                         input logic s);
        return s ? p - d : p + d;
    endfunction : step

    function automatic logic indir(input logic [11:0] a);
        return a >= `EXD_INDIR_LO && a <= `EXD_INDIR_HI;
    endfunction : indir

    task automatic finish_test();
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic chk_bit(input logic act, input logic exp);
        check_count++;
        if (act !== exp) begin
            num_errors++;
            $display("Error at %0t: flag got %b expected %b", $time, act, exp);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [20:0] act, input logic [20:0] exp);
        check_count++;
        if (act !== exp) begin
            num_errors++;
            $display("Error at %0t: value got %h expected %h", $time, act, exp);
        end
    endtask : chk_val

    task automatic chk_ptrs();
        for (int i = 0; i < 3; i++)
            chk_val(21'(file_select_pointer[i]), 21'(ptr_m[i]));
    endtask : chk_ptrs

    task automatic rand_core();
        seed = xs(seed);
        pc_in = seed[20:0];
        working_register = seed[28:21];
        seed = xs(seed);
        return_stack_top = seed[20:0];
        seed = xs(seed);
        counter_latch_high = seed[7:0];
        counter_latch_upper = seed[12:8];
    endtask : rand_core

    // Called at a falling edge; leaves valid high so ops run back to back
    task automatic send(input logic [15:0] w, input logic claim);
        instr_valid = 1'b1;
        instr_word = w;
        #1;
        chk_bit(ext_claim, claim);
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : send

    // A push offered in the bubble must wait, then run exactly once
    task automatic bubble();
        instr_word = {`EXD_OP_PUSH_LIT, 8'h77};
        #1;
        chk_bit(instr_ready, 1'b0);
        chk_bit(ext_claim, 1'b0);
        @(negedge clk_sys);
        chk_bit(instr_ready, 1'b1);
        chk_val(21'(strobes), 21'h0);
        chk_ptrs();
        do_push(8'h77);
    endtask : bubble

    task automatic do_ptr(input logic sub, input logic [1:0] sel, input logic [5:0] k);
        logic [1:0] ix;
        ix = (sel == `EXD_SEL_RETURN) ? 2'd2 : sel;
        rand_core();
        send({sub ? `EXD_OP_SUB_PTR : `EXD_OP_ADD_PTR, sel, k}, 1'b1);
        ptr_m[ix] = step(ptr_m[ix], {6'h00, k}, sub);
        chk_ptrs();
        if (sel == `EXD_SEL_RETURN) begin
            chk_val(21'(strobes), 21'h14);
            chk_val(pc_load_value_q, return_stack_top);
            bubble();
        end else begin
            chk_val(21'(strobes), 21'h0);
        end
    endtask : do_ptr

    task automatic do_call();
        rand_core();
        send(`EXD_OP_CALL_W, 1'b1);
        chk_val(21'(strobes), 21'h18);
        chk_val(stack_push_value_q, pc_in + 21'd2);
        chk_val(pc_load_value_q, {counter_latch_upper, counter_latch_high,
                                  working_register});
        chk_ptrs();
        bubble();
    endtask : do_call

    task automatic do_push(input logic [7:0] k);
        logic [11:0] old;
        old = ptr_m[2];
        send({`EXD_OP_PUSH_LIT, k}, 1'b1);
        ptr_m[2] = step(old, `EXD_PUSH_STEP, 1'b1);
        chk_val(21'(strobes), 21'h01);
        chk_val(21'({mem_wr_addr_q, mem_wr_data_q}), 21'({old, k}));
        chk_ptrs();
    endtask : do_push

    task automatic do_move(input logic ix, input logic [6:0] zs, input logic [11:0] dst);
        logic [11:0] src, da;
        logic        wr;
        src = ptr_m[2] + {5'h00, zs};
        da = ix ? ptr_m[2] + {5'h00, dst[6:0]} : dst;
        wr = !(ix && indir(da));
        send({`EXD_OP_MOVE_IDX, ix, zs}, 1'b1);
        chk_val(21'(strobes), 21'h02);
        chk_val(21'(mem_rd_addr_q), 21'(src));
        if (dst[11]) begin
            // Late second word: the byte held from the read must be used
            instr_valid = 1'b0;
            @(negedge clk_sys);
            chk_bit(mem_rd_en_q, 1'b0);
        end
        send({`EXD_W2_PREFIX, dst}, 1'b1);
        chk_bit(mem_wr_en_q, wr);
        if (wr)
            chk_val(21'({mem_wr_addr_q, mem_wr_data_q}),
                    21'({da, indir(src) ? 8'h00 : mval(src)}));
        chk_ptrs();
    endtask : do_move

    task automatic do_reset();
        rstn = 1'b0;
        instr_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        for (int i = 0; i < 3; i++)
            ptr_m[i] = `EXD_PTR_RST;
        chk_val(21'(strobes), 21'h0);
        chk_bit(instr_ready, 1'b1);
        chk_ptrs();
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        // Run needs well under a thousand cycles
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        do_reset();
        // Disabled set: words ignored entirely
        extended_set_enable = 1'b0;
        send({`EXD_OP_ADD_PTR, 2'b00, 6'h3f}, 1'b0);
        send(`EXD_OP_CALL_W, 1'b0);
        chk_val(21'(strobes), 21'h0);
        chk_ptrs();
        extended_set_enable = 1'b1;
        // Near-miss word, then a move aborted by a bad second word
        send(16'h0015, 1'b0);
        chk_val(21'(strobes), 21'h0);
        send({`EXD_OP_MOVE_IDX, 8'h01}, 1'b1);
        send(16'h7abc, 1'b1);
        chk_bit(mem_wr_en_q, 1'b0);
        send(16'h0f12, 1'b0);
        chk_val(21'(strobes), 21'h0);
        chk_ptrs();
        // Push from zero wraps the frame pointer
        do_push(8'h5c);
        do_ptr(1'b0, 2'd2, 6'h3f);
        do_ptr(1'b1, 2'd0, 6'h01);
        for (int n = 0; n < 200; n++) begin
            seed = xs(seed);
            case (seed[31:29] % 6)
                0: do_ptr(seed[8], 2'(seed[7:6] % 3), seed[5:0]);
                1: do_ptr(seed[8], `EXD_SEL_RETURN, seed[5:0]);
                2: do_call();
                3: do_push(seed[7:0]);
                default: do_move(seed[29], seed[6:0], seed[19:8]);
            endcase
        end
        // Indirect window corners after a mid-run reset
        do_reset();
        do_push(8'h11);
        do_ptr(1'b1, 2'd2, 6'h1f);
        do_move(1'b1, 7'h05, 12'hf30);
        do_move(1'b1, 7'h30, 12'h003);
        do_move(1'b0, 7'h02, 12'hfe4);
        instr_valid = 1'b0;
        @(negedge clk_sys);
        finish_test();
    end

endmodule : exd_decode_bench
